// ### verilog/bqc_counter.v
// Counter core for one incremental encoder channel, with wrap limits.
// Assumes track and gate inputs are synchronous or slow against ref_clk_i,
// and that the controller drives configuration ports as steady levels.
`timescale 1ns/1ps
`default_nettype none
`include "bqc_consts.vh"

// Function
// - Limit write needs lower strictly below upper
// - Limit writes only with unlock key loaded
// - Out-of-range preset loads and flags outside
// - Limits moved past count flag outside
// - Down from lower wraps to upper, flag
// - Below-wrap flag clears under two-thirds threshold
// - Up from upper wraps to lower, flag
// - Above-wrap flag clears over one-third threshold
// - Quadrature: A leading B counts forward
// - Pulse types: B low forward, high reverse
// - Direction invert reverses all counting
// - Report live track B level
// - Differential pulse type flags open B wire
// - Gate edge loads reset value, no rearm
// - Edge select: zero falling, one rising
// - No confirmation for edge reset
// - Reset applies first, then gate blocks
// - Edge reset settings persist as configuration
// - Even codes quadrature, odd codes pulse
// - One, two or four-fold evaluation
module bqc_counter (
	// Clock and reset
	input  wire                    ref_clk_i,
	input  wire                    rst_i,
	// Encoder and gate/latch pins
	input  wire                    track_a_i,
	input  wire                    track_b_i,
	input  wire                    track_b_open_i,
	input  wire                    gate_latch_i,
	// Counting configuration
	input  wire [2:0]              counter_mode_i,
	input  wire [1:0]              eval_mode_i,
	input  wire                    direction_invert_i,
	input  wire                    wire_check_en_i,
	// Limit writes
	input  wire [31:0]             unlock_key_i,
	input  wire                    limit_lo_wr_i,
	input  wire                    limit_hi_wr_i,
	input  wire [`BQC_CW-1:0]      limit_data_i,
	// Preset load
	input  wire                    preset_load_i,
	input  wire [`BQC_CW-1:0]      preset_value_i,
	// External edge reset and gate
	input  wire                    edge_zero_en_i,
	input  wire                    zero_edge_sel_i,
	input  wire [`BQC_CW-1:0]      reset_value_i,
	input  wire [1:0]              gate_sel_i,
	// Count and limits
	output reg  [`BQC_CW-1:0]      count_o,
	output reg  [`BQC_CW-1:0]      limit_lo_o,
	output reg  [`BQC_CW-1:0]      limit_hi_o,
	output reg                     limit_reject_o,
	// Status
	output reg                     wrap_below_o,
	output reg                     wrap_above_o,
	output reg                     count_outside_bounds_o,
	output reg                     track_b_level_o,
	output reg                     track_b_error_o,
	output reg                     count_blocked_o
);

	// Synchronised levels and previous levels: bit 0 A, 1 B, 2 gate
	wire [2:0] lvl;
	wire [2:0] prv;

	// Edge flags decoded from the synchronised pairs
	reg  a_edge;      // Any edge on A
	reg  a_rise;      // Rising edge on A
	reg  b_edge;      // Any edge on B
	reg  g_rise;      // Rising edge on gate/latch
	reg  g_fall;      // Falling edge on gate/latch

	// Counting decisions for this cycle
	reg  quad;        // Encoder type is quadrature
	reg  step;        // One count step is due
	reg  raw_up;      // Direction before inversion
	reg  up;          // Final direction
	reg  b_dir;       // Track B as seen for pulse direction
	reg  zero_hit;    // Qualifying gate edge for the reset value
	reg  blocked;     // Gate holds the count

	// Next values of the count and flags
	reg  [`BQC_CW-1:0] next_count;
	reg                next_below;
	reg                next_above;
	reg                wrap_dn;   // Wrap from lower to upper this cycle
	reg                wrap_upw;  // Wrap from upper to lower this cycle

	// Limit write decisions
	reg                key_ok;    // Unlock key present
	reg                lo_ok;     // Lower limit write accepted
	reg                hi_ok;     // Upper limit write accepted

	// Hysteresis thresholds
	wire [`BQC_CW-1:0] thr_under;
	wire [`BQC_CW-1:0] thr_over;

	// Start-up mask for the edge detector
	reg  [1:0]         settle;    // Cycles since reset, stops at the last value
	reg                edges_ok;  // Synchroniser holds real pin levels

	// Lower limit plus the given thirds of the span, in wide arithmetic
	function [`BQC_CW-1:0] bqc_thirds;
		input [`BQC_CW-1:0] lo;
		input [`BQC_CW-1:0] hi;
		input [1:0]         num;
		reg   [`BQC_CW+1:0] span;
		reg   [`BQC_CW+1:0] part;
		begin
			span = {2'h0, hi} - {2'h0, lo};
			part = (span * {{`BQC_CW{1'b0}}, num}) / 34'h3;
			bqc_thirds = lo + part[`BQC_CW-1:0];
		end
	endfunction

	// Synchroniser for A, B and gate; edges judged from its output
	bqc_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.raw_i     ({gate_latch_i, track_b_i, track_a_i}),
		.level_o   (lvl),
		.prev_o    (prv)
	);

	// Thresholds follow the limits; the span never exceeds the count width
	// Floor division; neither clear point passes the opposite limit
	assign thr_under = bqc_thirds(limit_lo_o, limit_hi_o, `BQC_THIRD_UNDER);
	assign thr_over  = bqc_thirds(limit_lo_o, limit_hi_o, `BQC_THIRD_OVER);

	// Settling counter: the chain resets to zero, so a pin idling high would
	// look like a rising edge just after reset. Those cycles are masked; a real
	// pin edge in the first three cycles is lost, which start-up can afford.
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			settle <= 2'h0;
		end else if (settle != `BQC_SETTLE_LAST) begin
			settle <= settle + 2'h1;
		end
	end

	// Edge decode from the second and third stages only
	always @* begin
		// Masked edges neither count nor reset the count
		edges_ok = (settle == `BQC_SETTLE_LAST);
		a_edge   = edges_ok & (lvl[0] ^ prv[0]);
		a_rise   = edges_ok & lvl[0] & ~prv[0];
		b_edge   = edges_ok & (lvl[1] ^ prv[1]);
		g_rise   = edges_ok & lvl[2] & ~prv[2];
		g_fall   = edges_ok & ~lvl[2] & prv[2];
	end

	// Step and direction selection
	always @* begin
		// Odd codes are pulse generators, even codes quadrature
		quad   = ~counter_mode_i[0];
		// An open B wire reads as low, so it counts forward
		b_dir  = lvl[1] & ~track_b_open_i;
		step   = 1'b0;
		raw_up = 1'b1;
		if (quad) begin
			// A leading B: new A differs from B on A edges
			case (eval_mode_i)
				`BQC_EVAL_X4: begin
					if (a_edge) begin
						step   = 1'b1;
						raw_up = lvl[0] ^ lvl[1];
					end else if (b_edge) begin
						step   = 1'b1;
						raw_up = ~(lvl[0] ^ lvl[1]);
					end
				end
				`BQC_EVAL_X2: begin
					step   = a_edge;
					raw_up = lvl[0] ^ lvl[1];
				end
				`BQC_EVAL_X1: begin
					step   = a_rise;
					raw_up = ~lvl[1];
				end
				default: begin
					// Unused code counts nothing
					step   = 1'b0;
					raw_up = 1'b1;
				end
			endcase
		end else begin
			// Pulses on A; B edges carry no count in these types
			// Direction is the B level seen at the same edge as the pulse
			case (eval_mode_i)
				`BQC_EVAL_X1: step = a_rise;
				`BQC_EVAL_X2: step = a_edge;
				`BQC_EVAL_X4: step = a_edge;
				default:      step = 1'b0;
			endcase
			raw_up = ~b_dir;
		end
		// Inversion applies after the type decision
		up = raw_up ^ direction_invert_i;
		// Codes above the last defined one count nothing
		if (counter_mode_i > `BQC_MODE_LAST) begin
			step = 1'b0;
		end
	end

	// Gate and external edge reset
	always @* begin
		// Edge select: one rising, zero falling; enable is a plain level
		zero_hit = edge_zero_en_i &
			(zero_edge_sel_i ? g_rise : g_fall);
		// Gate level blocks counting; the reset is not blocked
		// Codes 0 and 3 leave the count free to move
		case (gate_sel_i)
			`BQC_GATE_POS: blocked = lvl[2];
			`BQC_GATE_NEG: blocked = ~lvl[2];
			default:       blocked = 1'b0;
		endcase
	end

	// Next count and wrap flags
	always @* begin
		next_count = count_o;
		wrap_dn    = 1'b0;
		wrap_upw   = 1'b0;
		if (preset_load_i) begin
			// Loaded as given, even outside the limits
			next_count = preset_value_i;
		end else if (zero_hit) begin
			// Reset wins over the gate on the same edge
			next_count = reset_value_i;
		end else if (step && !blocked) begin
			// Outside the limits the count steps plainly; only equality wraps
			if (up) begin
				if (count_o == limit_hi_o) begin
					next_count = limit_lo_o;
					wrap_upw   = 1'b1;
				end else begin
					next_count = count_o + 32'h00000001;
				end
			end else begin
				if (count_o == limit_lo_o) begin
					next_count = limit_hi_o;
					wrap_dn    = 1'b1;
				end else begin
					next_count = count_o - 32'h00000001;
				end
			end
		end
		// Hysteresis clear; a fresh wrap overrides the clear
		next_below = wrap_below_o;
		if (count_o < thr_under) begin
			next_below = 1'b0;
		end
		if (wrap_dn) begin
			next_below = 1'b1;
		end
		next_above = wrap_above_o;
		if (count_o > thr_over) begin
			next_above = 1'b0;
		end
		if (wrap_upw) begin
			next_above = 1'b1;
		end
	end

	// Limit write checks; a wrong key is ignored without a reject pulse
	always @* begin
		key_ok = (unlock_key_i == `BQC_UNLOCK_KEY);
		// Lower write has priority if both strobes come together
		lo_ok  = key_ok & limit_lo_wr_i & (limit_data_i < limit_hi_o);
		hi_ok  = key_ok & limit_hi_wr_i & ~limit_lo_wr_i &
			(limit_lo_o < limit_data_i);
	end

	// Limit registers and reject pulse
	// Both strobes at once write only the lower limit
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			limit_lo_o     <= `BQC_LO_RST;
			limit_hi_o     <= `BQC_HI_RST;
			limit_reject_o <= 1'b0;
		end else begin
			if (lo_ok) begin
				limit_lo_o <= limit_data_i;
			end
			if (hi_ok) begin
				limit_hi_o <= limit_data_i;
			end
			// A refused value leaves both limits as they were
			// Rejected: unlocked strobe whose value breaks the ordering
			limit_reject_o <= key_ok & (limit_lo_wr_i | limit_hi_wr_i) &
				~lo_ok & ~hi_ok;
		end
	end

	// Count and wrap flags; an edge reset raises no acknowledge
	// Every load applies at once; no done bit exists to confirm it
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_o      <= `BQC_CNT_RST;
			wrap_below_o <= 1'b0;
			wrap_above_o <= 1'b0;
		end else begin
			count_o      <= next_count;
			wrap_below_o <= next_below;
			wrap_above_o <= next_above;
		end
	end

	// Status bits, one cycle behind the count and limits
	// The outside flag therefore trails a preset or limit change by a cycle
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_outside_bounds_o <= 1'b0;
			track_b_level_o        <= 1'b0;
			track_b_error_o        <= 1'b0;
			count_blocked_o        <= 1'b0;
		end else begin
			// Compared with the current limits, so a limit change counts too
			count_outside_bounds_o <= (count_o < limit_lo_o) |
				(count_o > limit_hi_o);
			// B level as the counter sees it, after synchronisation
			track_b_level_o <= lvl[1];
			// Only the differential pulse type can sense an open B wire
			track_b_error_o <= wire_check_en_i & track_b_open_i &
				(counter_mode_i == `BQC_MODE_DIFF_PG);
			count_blocked_o <= blocked;
		end
	end

endmodule

`default_nettype wire

// ### inc/bqc_consts.vh
// Constants for the bounded quadrature counter core.
// Assumes inclusion by bare name from the counter core, the checker and the bench.
`ifndef BQC_CONSTS_VH
`define BQC_CONSTS_VH

// Width of the count and of every limit
`define BQC_CW            32
// Key that unlocks writes to the limits
`define BQC_UNLOCK_KEY    32'h72657375
// Limit and count values after reset
`define BQC_LO_RST        32'h00000000
`define BQC_HI_RST        32'hFFFFFFFF
`define BQC_CNT_RST       32'h00000000
// Encoder-type codes
`define BQC_MODE_DIFF_PG  3'h1
`define BQC_MODE_LAST     3'h5
// Evaluation modes
`define BQC_EVAL_X4       2'h0
`define BQC_EVAL_X2       2'h1
`define BQC_EVAL_X1       2'h2
// Gate level select
`define BQC_GATE_POS      2'h1
`define BQC_GATE_NEG      2'h2
// Hysteresis fractions, in thirds of the span
`define BQC_THIRD_UNDER   2'h2
`define BQC_THIRD_OVER    2'h1
// Last value of the start-up settling count
`define BQC_SETTLE_LAST   2'h3

`endif

// ### verilog/bqc_sync.v
// Two-stage synchroniser with one extra stage for edge detection.
// Assumes the inputs are plain levels; the system clock is ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module bqc_sync (
	// Clock and reset
	input  wire       ref_clk_i,
	input  wire       rst_i,
	// Raw levels: track A, track B, gate/latch
	input  wire [2:0] raw_i,
	// Synchronised level and its value one cycle earlier
	output reg  [2:0] level_o,
	output reg  [2:0] prev_o
);

	reg [2:0] meta;  // First stage, read only by the second

	// Shift chain; edges are seen between level_o and prev_o only
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			meta    <= 3'h0;
			level_o <= 3'h0;
			prev_o  <= 3'h0;
		end else begin
			meta    <= raw_i;
			level_o <= meta;
			prev_o  <= level_o;
		end
	end

endmodule

`default_nettype wire

// ### test/bqc_counter_monitor.sv
// Checker for the counter core, bound to its ports.
// Assumes limits, count and flags are registers on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bqc_consts.vh"
module bqc_counter_monitor (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	// Strobes
	input wire logic        limit_lo_wr_i,
	input wire logic        limit_hi_wr_i,
	input wire logic        preset_load_i,
	// Data in
	input wire logic [31:0] unlock_key_i,
	input wire logic [31:0] limit_data_i,
	input wire logic [31:0] preset_value_i,
	// Count and limits
	input wire logic [31:0] count_o,
	input wire logic [31:0] limit_lo_o,
	input wire logic [31:0] limit_hi_o,
	// Flags
	input wire logic        limit_reject_o,
	input wire logic        wrap_below_o,
	input wire logic        wrap_above_o,
	input wire logic        count_outside_bounds_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Wide so the doubled span cannot overflow
	wire logic [63:0] span = 64'(limit_hi_o - limit_lo_o);
	wire logic [63:0] thr_b = limit_lo_o + span * 2 / 3;
	wire logic [63:0] thr_a = limit_lo_o + span / 3;
	a_lo_reject: assert property (limit_lo_wr_i && unlock_key_i == `BQC_UNLOCK_KEY &&
		limit_data_i >= limit_hi_o |=> limit_reject_o && $stable(limit_lo_o)) else $error("lo taken");
	a_key_lock: assert property ((limit_lo_wr_i || limit_hi_wr_i) &&
		unlock_key_i != `BQC_UNLOCK_KEY |=> $stable(limit_lo_o) && $stable(limit_hi_o)
		&& !limit_reject_o) else $error("locked write acted");
	a_preset_load: assert property (preset_load_i |=> count_o == $past(preset_value_i))
		else $error("preset lost");
	a_outside_flag: assert property (!$past(rst_i) |-> count_outside_bounds_o ==
		($past(count_o) < $past(limit_lo_o) || $past(count_o) > $past(limit_hi_o)))
		else $error("outside flag wrong");
	a_wrap_up: assert property ($rose(wrap_above_o) |-> count_o == limit_lo_o &&
		$past(count_o) == $past(limit_hi_o)) else $error("bad up wrap");
	a_wrap_down: assert property ($rose(wrap_below_o) |-> count_o == limit_hi_o &&
		$past(count_o) == $past(limit_lo_o)) else $error("bad down wrap");
	a_below_clear: assert property (wrap_below_o && count_o < thr_b |=>
		!wrap_below_o || count_o == limit_hi_o) else $error("below flag kept");
	a_above_clear: assert property (wrap_above_o && count_o > thr_a |=>
		!wrap_above_o || count_o == limit_lo_o) else $error("above flag kept");
	c_reject: cover property (limit_reject_o);
	c_outside: cover property ($rose(count_outside_bounds_o));
	c_wrap_up: cover property ($rose(wrap_above_o));
	c_wrap_down: cover property ($rose(wrap_below_o));
endmodule
bind bqc_counter bqc_counter_monitor bqc_counter_monitor_inst (.*);
`default_nettype wire

// ### test/bqc_enc_model.sv
// Encoder model: quadrature or pulse/direction source.
// Assumes step requests spaced several clocks apart.
`timescale 1ns/1ps
`default_nettype none
module bqc_enc_model (
	// Clock and step request
	input  wire logic ref_clk_i,
	input  wire logic step_i,
	input  wire logic up_i,
	input  wire logic pulse_i,
	// Tracks
	output wire logic track_a_o,
	output wire logic track_b_o
);
	logic [1:0] ph = 2'h0; // Shaft phase
	// One quarter period per step
	always @(posedge ref_clk_i)
		if (step_i)
			ph <= up_i ? ph + 2'h1 : ph - 2'h1;
	// A leads B going up; pulse type toggles A
	assign track_a_o = pulse_i ? ph[0] : ph[0] ^ ph[1];
	// Direction level leads the pulse by a clock
	assign track_b_o = pulse_i ? ~up_i : ph[1];
endmodule
`default_nettype wire

// ### test/bqc_counter_test.sv
// Bench for the counter core with an encoder model.
// Assumes the checker is bound to the counter.
`timescale 1ns/1ps
`default_nettype none
`include "bqc_consts.vh"
module bqc_counter_test;
	logic clk = 1'b0, rst = 1'b1, stp = 1'b0, dir = 1'b1, pm = 1'b0, bo = 1'b0, gl = 1'b0;
	logic inv = 1'b0, wc = 1'b0, lw = 1'b0, hw = 1'b0, pl = 1'b0, ez = 1'b0, zs = 1'b0, blk = 1'b0;
	logic [2:0] cm = 3'h0;
	logic [1:0] ev = 2'h0, gs = 2'h0;
	logic [31:0] key = 32'h0, ld = 32'h0, pv = 32'h0, rv = 32'h0, ec = 32'h0, pc = 32'h0;
	logic [31:0] lo = `BQC_LO_RST, hi = `BQC_HI_RST;
	logic [31:0] expq[$]; // Expected counts, oldest first
	integer seed = 32'hCA8324BD;
	int num_errors = 0, checks_done = 0;
	wire logic ta, tb, rej, wb, wa, ob, bl, be, blo;
	wire logic [31:0] cnt, lo_o, hi_o;
	initial forever #10 clk = ~clk;
	bqc_enc_model bqc_enc_model_inst (.ref_clk_i(clk), .step_i(stp), .up_i(dir), .pulse_i(pm),
		.track_a_o(ta), .track_b_o(tb));
	bqc_counter bqc_counter_inst (.ref_clk_i(clk), .rst_i(rst), .track_a_i(ta), .track_b_i(tb),
		.track_b_open_i(bo), .gate_latch_i(gl), .counter_mode_i(cm), .eval_mode_i(ev),
		.direction_invert_i(inv), .wire_check_en_i(wc), .unlock_key_i(key), .limit_lo_wr_i(lw),
		.limit_hi_wr_i(hw), .limit_data_i(ld), .preset_load_i(pl), .preset_value_i(pv),
		.edge_zero_en_i(ez), .zero_edge_sel_i(zs), .reset_value_i(rv), .gate_sel_i(gs),
		.count_o(cnt), .limit_lo_o(lo_o), .limit_hi_o(hi_o), .limit_reject_o(rej),
		.wrap_below_o(wb), .wrap_above_o(wa), .count_outside_bounds_o(ob),
		.track_b_level_o(blo), .track_b_error_o(be), .count_blocked_o(bl));
	task chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task complete_run;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Limit write; outcome worked out from key and order
	task wl(input logic h, input logic [31:0] d, k);
		logic ok;
		ok = k == `BQC_UNLOCK_KEY && (h ? lo < d : d < hi);
		key = k;
		ld = d;
		lw = !h;
		hw = h;
		cyc(1);
		lw = 1'b0;
		hw = 1'b0;
		chk(rej, k == `BQC_UNLOCK_KEY && !ok);
		if (ok && h)
			hi = d;
		else if (ok)
			lo = d;
		chk(h ? hi_o : lo_o, h ? hi : lo);
		// Strobes stay low for a full cycle before the next write
		cyc(1);
	endtask
	// One encoder step; count it only where the mode sees an edge
	task step(input logic up);
		logic a0;
		a0 = ta;
		dir = up;
		stp = 1'b1;
		cyc(1);
		stp = 1'b0;
		if ((ev == 2'h0 || pm || (ev == 2'h1 ? a0 != ta : !a0 && ta)) && !blk) begin
			ec = (up ^ inv) ? (ec == hi ? lo : ec + 1) : (ec == lo ? hi : ec - 1);
			expq.push_back(ec);
		end
		cyc(5);
	endtask
	task preset(input logic [31:0] v);
		pv = v;
		pl = 1'b1;
		cyc(1);
		pl = 1'b0;
		ec = v;
		expq.push_back(v);
		cyc(3);
	endtask
	// Every count change must match the oldest note
	always @(posedge clk) begin
		if (!rst && cnt !== pc)
			chk(cnt, expq.size() > 0 ? expq.pop_front() : ~cnt);
		pc = cnt;
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		complete_run;
	end
	initial begin
		cyc(5);
		rst = 1'b0;
		cyc(3);
		// Reset values of count, limits and flags; the three flags share one compare
		chk(cnt, `BQC_CNT_RST);
		chk(lo_o, `BQC_LO_RST);
		chk(hi_o, `BQC_HI_RST);
		chk({29'h0, wa, wb, ob}, 32'h0);
		wl(1'b1, 32'hFFF, 32'h0);
		wl(1'b1, 32'hFFF, `BQC_UNLOCK_KEY);
		wl(1'b0, 32'h1388, `BQC_UNLOCK_KEY);
		wl(1'b0, 32'h190, `BQC_UNLOCK_KEY);
		$display("limit test done");
		preset(32'hFFE);
		repeat (3) step(1'b1);
		chk(wa, 1'b1);
		preset(32'hBB8);
		chk(wa, 1'b0);
		preset(32'h191);
		repeat (2) step(1'b0);
		chk(wb, 1'b1);
		preset(32'h3E8);
		chk(wb, 1'b0);
		preset(32'h1388);
		chk(ob, 1'b1);
		preset(32'h3E8);
		wl(1'b1, 32'h384, `BQC_UNLOCK_KEY);
		cyc(2);
		chk(ob, 1'b1);
		wl(1'b1, 32'hFFF, `BQC_UNLOCK_KEY);
		$display("wrap test done");
		for (int m = 0; m < 6; m++) begin
			ev = 2'(m % 3);
			inv = 1'(m / 3);
			cm = 3'(2 * ($unsigned($random(seed)) % 3));
			repeat (6) step(1'($random(seed)));
		end
		// Mode change moves track A, so counting is off meanwhile
		ev = 2'h3;
		pm = 1'b1;
		cyc(5);
		ev = 2'h1;
		for (int m = 0; m < 6; m++) begin
			cm = 3'(2 * (m % 3) + 1);
			inv = 1'(m / 3);
			repeat (4) step(1'($random(seed)));
		end
		// Codes above the last type count nothing; any change is a mismatch
		cm = 3'h6;
		blk = 1'b1;
		step(1'b1);
		blk = 1'b0;
		// Track B level must follow the pin both ways
		chk(blo, tb);
		dir = !dir;
		cyc(4);
		chk(blo, tb);
		// Open wire is only sensed in the differential pulse type
		cm = `BQC_MODE_DIFF_PG;
		wc = 1'b1;
		bo = 1'b1;
		cyc(2);
		chk(be, 1'b1);
		cm = 3'h3;
		cyc(2);
		chk(be, 1'b0);
		cm = `BQC_MODE_DIFF_PG;
		wc = 1'b0;
		cyc(2);
		chk(be, 1'b0);
		bo = 1'b0;
		$display("direction test done");
		ez = 1'b1;
		zs = 1'($random(seed));
		rv = 32'h190 + ($unsigned($random(seed)) & 32'hFF);
		for (int k = 0; k < 3; k++) begin
			gl = !zs;
			cyc(5);
			gs = k == 2 ? (zs ? `BQC_GATE_POS : `BQC_GATE_NEG) : 2'h0;
			step(1'b1);
			gl = zs;
			if (ec != rv)
				expq.push_back(rv);
			ec = rv;
			cyc(5);
		end
		blk = 1'b1;
		step(1'b1);
		chk(bl, 1'b1);
		$display("edge reset test done");
		cyc(5);
		chk(expq.size(), 32'h0);
		complete_run;
	end
endmodule
`default_nettype wire
